//--- pkg/flow_ctl_pkg.sv
// Constants for the receive-side automatic flow controller.
// Assumes a 40 MHz system clock; all timing counts derive from it.
package flow_ctl_pkg;
  localparam int CLK_MHZ = 40;
  localparam int FIFO_CNT_W = 14;
  localparam int UNIT_SHIFT = 6;
  localparam int THR_W = 8;
  localparam int DUR_W = 4;
  localparam int QUAL_ANY_POS = 0;
  localparam int QUAL_OWN_POS = 1;
  localparam int QUAL_BRD_POS = 2;
  localparam int QUAL_MULT_POS = 3;
  localparam logic [3:0] QUAL_RESET = 4'h0;
  localparam logic [7:0] THR_RESET = 8'h00;
  localparam logic [3:0] DUR_RESET = 4'h0;
  localparam int DUR_SHORT_LAST = 3;
  localparam int DUR_STEP_US = 5;
  localparam int DUR_CODE3_US = 25;
  localparam int DUR_LONG_STEP_US = 50;
  localparam int DUR_10M_EXTRA_NS = 2200;
  localparam int DUR_10M_EXTRA_CYC = DUR_10M_EXTRA_NS * CLK_MHZ / 1000;
  localparam int JAM_CNT_W = 15;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
endpackage : flow_ctl_pkg

//--- design/jam_timer.sv
// Jam duration timer: decodes the duration code and counts it down.
// Assumes load_i is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
module jam_timer (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       load_i,
  input  wire logic [3:0] code_i,
  input  wire logic       speed_100_i,
  output logic            busy_o
);
  logic [flow_ctl_pkg::JAM_CNT_W-1:0] cnt_reg;
  logic [flow_ctl_pkg::JAM_CNT_W-1:0] cnt_next;
  logic                               busy_next;

  function automatic logic [flow_ctl_pkg::JAM_CNT_W-1:0] dur_cycles(
    input logic [3:0] code, input logic fast);
    int us;
    int cyc;
    us = 0;
    if (int'(code) <= flow_ctl_pkg::DUR_SHORT_LAST) begin
      us = (int'(code) == flow_ctl_pkg::DUR_SHORT_LAST) ? flow_ctl_pkg::DUR_CODE3_US
           : (int'(code) + 1) * flow_ctl_pkg::DUR_STEP_US;
    end else begin
      us = (int'(code) - flow_ctl_pkg::DUR_SHORT_LAST) * flow_ctl_pkg::DUR_LONG_STEP_US;
    end
    cyc = us * flow_ctl_pkg::CLK_MHZ;
    if (!fast) begin
      cyc = cyc + flow_ctl_pkg::DUR_10M_EXTRA_CYC;
    end
    dur_cycles = cyc[flow_ctl_pkg::JAM_CNT_W-1:0];
  endfunction : dur_cycles

  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = dur_cycles(code_i, speed_100_i); // [R6] [R11]
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1; // [R11]
    end
    busy_next = (cnt_next != '0);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      busy_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_o  <= busy_next;
    end
  end

  load_busy_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R11]
    load_i |=> busy_o) else $error("jam timer did not start");
endmodule : jam_timer

//--- design/rx_auto_flow_control.sv
// Receive automatic flow controller: back pressure or pause requests.
// Assumes frame events are one-cycle pulses from the MAC receive path.
//
// How it works
// R1: Any-frame qualifier triggers at level; resets zero.
// R2: Full duplex flow control only with any-frame.
// R3: Half duplex any-frame reacts at preamble.
// R4: Full duplex requests pause once level reached.
// R5: Any-frame overrides multicast, broadcast, own-address.
// R6: Duration code decodes per speed table.
// R7: High threshold in 64-byte units triggers.
// R8: Zero pause after drop below low.
// R9: Half duplex jams matching frames for duration.
// R10: Half duplex qualifiers: multicast, broadcast, own.
// R11: Counter on system clock times the jam.
`timescale 1ns/10ps
module rx_auto_flow_control (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        any_frame_qualifier_i,
  input  wire logic        multicast_qualifier_i,
  input  wire logic        broadcast_qualifier_i,
  input  wire logic        own_address_qualifier_i,
  input  wire logic [7:0]  flow_high_threshold_i,
  input  wire logic [7:0]  flow_low_threshold_i,
  input  wire logic [3:0]  jam_duration_code_i,
  input  wire logic [15:0] pause_time_value_i,
  input  wire logic        full_duplex_i,
  input  wire logic        speed_100_i,
  input  wire logic [13:0] rx_fifo_used_i,
  input  wire logic        rx_preamble_i,
  input  wire logic        rx_addr_valid_i,
  input  wire logic        rx_multicast_i,
  input  wire logic        rx_broadcast_i,
  input  wire logic        rx_own_addr_i,
  input  wire logic        pause_ack_i,
  output logic             jam_o,
  output logic             pause_req_o,
  output logic [15:0]      pause_time_o,
  output logic             above_high_o
);
  // ------------------------------------------------------------
  // Level compare
  // ------------------------------------------------------------
  // Thresholds count 64-byte units; the FIFO level counts bytes
  function automatic logic [13:0] units_to_bytes(input logic [7:0] units);
    units_to_bytes = 14'(units) << flow_ctl_pkg::UNIT_SHIFT;
  endfunction : units_to_bytes

  // Software keeps the low level below the high one
  logic [13:0] high_bytes;
  logic [13:0] low_bytes;
  logic        at_high;
  logic        below_low;
  assign high_bytes = units_to_bytes(flow_high_threshold_i); // [R7]
  assign low_bytes  = units_to_bytes(flow_low_threshold_i); // [R8]
  assign at_high    = (rx_fifo_used_i >= high_bytes); // [R7]
  assign below_low  = (rx_fifo_used_i < low_bytes); // [R8]

  // ------------------------------------------------------------
  // Half duplex trigger
  // ------------------------------------------------------------
  logic hd_match;
  logic jam_load;
  logic jam_busy;
  // Any-frame skips address decode and reacts on the preamble
  always_comb begin
    hd_match = 1'b0;
    if (any_frame_qualifier_i) begin
      hd_match = rx_preamble_i; // [R3] [R5]
    end else if (rx_addr_valid_i) begin
      hd_match = (multicast_qualifier_i & rx_multicast_i)
               | (broadcast_qualifier_i & rx_broadcast_i)
               | (own_address_qualifier_i & rx_own_addr_i); // [R10]
    end
  end
  // Retrigger only when idle, so a long jam is not stretched forever
  assign jam_load = !full_duplex_i && at_high && hd_match && !jam_busy; // [R9] [R1]

  jam_timer jam_timer_inst (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .load_i      (jam_load),
    .code_i      (jam_duration_code_i),
    .speed_100_i (speed_100_i),
    .busy_o      (jam_busy)
  );

  // A trigger loads the timer on the edge that sees it
  any_start_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R3] [R5]
    !full_duplex_i && any_frame_qualifier_i && at_high && rx_preamble_i && !jam_busy
    |=> jam_busy) else $error("preamble did not start a jam");
  qual_start_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R10]
    !full_duplex_i && !any_frame_qualifier_i && at_high && rx_addr_valid_i && !jam_busy
    && ((multicast_qualifier_i && rx_multicast_i) || (broadcast_qualifier_i && rx_broadcast_i)
    || (own_address_qualifier_i && rx_own_addr_i)) |=> jam_busy)
    else $error("qualified frame did not start a jam");
  below_high_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R7]
    !at_high && !jam_busy |=> !jam_busy) else $error("jam started below the level");
  jam_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R9]
    jam_load ##1 !full_duplex_i |=> jam_o) else $error("jam output did not follow");

  // ------------------------------------------------------------
  // Full duplex pause state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {FD_IDLE, FD_PAUSED} fd_state_t;
  fd_state_t   fd_reg;
  fd_state_t   fd_next;
  logic        req_reg;
  logic        req_next;
  logic [15:0] time_reg;
  logic [15:0] time_next;
  logic        fd_enable;
  assign fd_enable = full_duplex_i && any_frame_qualifier_i; // [R2]

  always_comb begin
    fd_next   = fd_reg;
    req_next  = req_reg;
    time_next = time_reg;
    if (req_reg && pause_ack_i) begin
      req_next = 1'b0; // [R4]
    end
    case (fd_reg)
      FD_IDLE: begin
        if (fd_enable && at_high && !req_reg) begin
          req_next  = 1'b1; // [R4] [R7]
          time_next = pause_time_value_i;
          fd_next   = FD_PAUSED;
        end
      end
      // Leaving flow control while paused sends no zero pause;
      // the zero pause waits until the high pause was taken
      FD_PAUSED: begin
        if (!fd_enable) begin
          fd_next = FD_IDLE;
        end else if (below_low && !req_next) begin
          req_next  = 1'b1; // [R8]
          time_next = flow_ctl_pkg::PAUSE_ZERO;
          fd_next   = FD_IDLE;
        end
      end
      default: fd_next = FD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fd_reg   <= FD_IDLE;
      req_reg  <= 1'b0;
      time_reg <= flow_ctl_pkg::PAUSE_ZERO;
    end else begin
      fd_reg   <= fd_next;
      req_reg  <= req_next;
      time_reg <= time_next;
    end
  end
  // Request and time leave straight from their registers
  assign pause_req_o  = req_reg;
  assign pause_time_o = time_reg;

  fd_quiet_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R2]
    !any_frame_qualifier_i && fd_reg == FD_IDLE && !req_reg |=> !pause_req_o)
    else $error("pause requested without any-frame");
  fd_leave_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R2]
    fd_reg == FD_PAUSED && !fd_enable |=> fd_reg == FD_IDLE)
    else $error("pause state kept without flow control");
  hd_nopause_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R2]
    !full_duplex_i && fd_reg == FD_IDLE && !pause_req_o |=> !pause_req_o)
    else $error("pause requested in half duplex");
  fd_request_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R4]
    fd_reg == FD_IDLE && fd_enable && at_high && !req_reg |=> pause_req_o)
    else $error("pause not requested at level");
  req_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R4]
    pause_req_o && !pause_ack_i |=> pause_req_o)
    else $error("pause request dropped early");
  ack_drop_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R4]
    pause_req_o && pause_ack_i && !(fd_reg == FD_PAUSED && fd_enable && below_low)
    |=> !pause_req_o) else $error("pause request kept after ack");
  pause_stable_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R4]
    pause_req_o && !pause_ack_i |=> $stable(pause_time_o))
    else $error("pause time changed while requested");

  pause_time_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R7]
    fd_reg == FD_IDLE && fd_enable && at_high && !req_reg
    |=> pause_time_o == $past(pause_time_value_i)) else $error("wrong pause time");
  single_pause_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R7]
    fd_reg == FD_PAUSED && !below_low |=> !$rose(pause_req_o))
    else $error("second pause at the high level");
  zero_pause_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R8]
    fd_reg == FD_PAUSED && fd_enable && below_low && !pause_req_o
    |=> pause_req_o && pause_time_o == flow_ctl_pkg::PAUSE_ZERO)
    else $error("zero pause not requested");

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  logic jam_next;
  logic above_next;
  always_comb begin
    // A link turning full duplex cuts a running jam on the next edge
    jam_next   = jam_busy && !full_duplex_i; // [R9]
    above_next = at_high; // [R7]
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      jam_o        <= 1'b0;
      above_high_o <= 1'b0;
    end else begin
      jam_o        <= jam_next;
      above_high_o <= above_next;
    end
  end

  hd_nojam_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R9]
    full_duplex_i |=> !jam_o) else $error("jam in full duplex");
  above_level_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R7]
    rx_fifo_used_i >= units_to_bytes(flow_high_threshold_i) |=> above_high_o)
    else $error("level flag not raised");
  below_level_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // [R7]
    rx_fifo_used_i < units_to_bytes(flow_high_threshold_i) |=> !above_high_o)
    else $error("level flag raised below the level");
endmodule : rx_auto_flow_control

//--- sim/mac_partner.sv
// MAC stand-in that acknowledges pause requests after a short wait.
// Assumes the request is a level held until it is acknowledged.
`timescale 1ns/10ps
module mac_partner (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic pause_req_i,
  output logic      pause_ack_o
);
  logic [3:0] cnt_reg;
  // Held request goes out at a later window, one ack per request
  always_ff @(posedge clk_sys_i) begin
    cnt_reg     <= (reset_i || !pause_req_i) ? 4'h0 : cnt_reg + 4'h1;
    pause_ack_o <= !reset_i && pause_req_i && cnt_reg == 4'h5;
  end
endmodule : mac_partner

//--- sim/rx_auto_flow_control_tb.sv
// Self-checking bench for the receive flow controller.
// Assumes a MAC stand-in that acknowledges pause requests.
`timescale 1ns/10ps
module rx_auto_flow_control_tb;
  logic clk_sys_i = 0, reset_i = 1, full_duplex_i = 0, speed_100_i = 1;
  logic any_frame_qualifier_i = 0, multicast_qualifier_i = 0;
  logic broadcast_qualifier_i = 0, own_address_qualifier_i = 0;
  logic rx_preamble_i = 0, rx_addr_valid_i = 0, rx_multicast_i = 0;
  logic rx_broadcast_i = 0, rx_own_addr_i = 0;
  logic pause_ack_i, jam_o, pause_req_o, above_high_o;
  logic [15:0] pause_time_o, pause_time_value_i = 16'h1234;
  logic [7:0]  flow_high_threshold_i = 8'h04, flow_low_threshold_i = 8'h02;
  logic [3:0]  jam_duration_code_i = 4'h0;
  logic [13:0] rx_fifo_used_i = 14'h0000;
  int n_fail = 0, checks = 0, cycles = 0;
  int len_tab[5] = '{200, 400, 600, 1000, 2000};

  rx_auto_flow_control rx_auto_flow_control_inst (
    .clk_sys_i               (clk_sys_i),
    .reset_i                 (reset_i),
    .any_frame_qualifier_i   (any_frame_qualifier_i),
    .multicast_qualifier_i   (multicast_qualifier_i),
    .broadcast_qualifier_i   (broadcast_qualifier_i),
    .own_address_qualifier_i (own_address_qualifier_i),
    .flow_high_threshold_i   (flow_high_threshold_i),
    .flow_low_threshold_i    (flow_low_threshold_i),
    .jam_duration_code_i     (jam_duration_code_i),
    .pause_time_value_i      (pause_time_value_i),
    .full_duplex_i           (full_duplex_i),
    .speed_100_i             (speed_100_i),
    .rx_fifo_used_i          (rx_fifo_used_i),
    .rx_preamble_i           (rx_preamble_i),
    .rx_addr_valid_i         (rx_addr_valid_i),
    .rx_multicast_i          (rx_multicast_i),
    .rx_broadcast_i          (rx_broadcast_i),
    .rx_own_addr_i           (rx_own_addr_i),
    .pause_ack_i             (pause_ack_i),
    .jam_o                   (jam_o),
    .pause_req_o             (pause_req_o),
    .pause_time_o            (pause_time_o),
    .above_high_o            (above_high_o)
  );
  mac_partner mac_partner_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .pause_req_i(pause_req_o), .pause_ack_o(pause_ack_i));

  always #12.5 clk_sys_i = ~clk_sys_i;
  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Frame event pulse, then count jam cycles
  task jam(input bit pre, input int e);
    int n;
    n = 0;
    if (pre) rx_preamble_i = 1;
    else rx_addr_valid_i = 1;
    cyc(1);
    rx_preamble_i = 0;
    rx_addr_valid_i = 0;
    cyc(1);
    while (jam_o === 1'b1 && n < 30000) begin
      n++;
      cyc(1);
    end
    chk(16'(n), 16'(e));
    cyc(4);
  endtask : jam
  task wait_drop();
    int n;
    for (n = 0; n < 20 && pause_req_o !== 1'b0; n++) cyc(1);
    chk(pause_req_o, 0);
  endtask : wait_drop

  // ----------------------------------------
  // Full duplex pause sequence
  // ----------------------------------------
  task t_full();
    full_duplex_i = 1;
    rx_fifo_used_i = 14'h00FF;
    cyc(3);
    chk(above_high_o, 0);
    rx_fifo_used_i = 14'h0100;
    cyc(4);
    chk(above_high_o, 1);
    chk(pause_req_o, 0);
    any_frame_qualifier_i = 1;
    cyc(2);
    chk(pause_req_o, 1);
    chk(pause_time_o, 16'h1234);
    wait_drop();
    jam(1, 0);
    rx_fifo_used_i = 14'h0080;
    cyc(4);
    chk(pause_req_o, 0);
    rx_fifo_used_i = 14'h007F;
    cyc(2);
    chk(pause_req_o, 1);
    chk(pause_time_o, 16'h0000);
    wait_drop();
    full_duplex_i = 0;
  endtask : t_full

  // ----------------------------------------
  // Half duplex back pressure
  // ----------------------------------------
  task t_half();
    rx_fifo_used_i = 14'h0100;
    for (int c = 0; c < 5; c++) begin
      jam_duration_code_i = 4'(c);
      jam(1, len_tab[c]);
    end
    jam_duration_code_i = 4'h0;
    speed_100_i = 0;
    jam(1, 288);
    speed_100_i = 1;
    any_frame_qualifier_i = 0;
    multicast_qualifier_i = 1;
    rx_broadcast_i = 1;
    jam(0, 0);
    rx_broadcast_i = 0;
    rx_multicast_i = 1;
    jam(0, 200);
    rx_multicast_i = 0;
    multicast_qualifier_i = 0;
    broadcast_qualifier_i = 1;
    rx_broadcast_i = 1;
    jam(0, 200);
    rx_broadcast_i = 0;
    broadcast_qualifier_i = 0;
    own_address_qualifier_i = 1;
    rx_own_addr_i = 1;
    jam(0, 200);
    rx_fifo_used_i = 14'h00FF;
    jam(0, 0);
    any_frame_qualifier_i = 1;
    jam(1, 0);
  endtask : t_half

  task close_out();
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    cyc(3);
    reset_i = 0;
    chk({jam_o, pause_req_o, above_high_o}, 0);
    t_full();
    t_half();
    close_out();
  end
endmodule : rx_auto_flow_control_tb
